// [core/rpc_pkg.sv]
/*
 * Shared constants and types for the relay plug-in control block: register
 * offsets, control bit positions, reset values, timing counts and the phase
 * encoding of the sequencer.
 * Assumes a 100 MHz system clock and a 16-bit register port with byte offsets
 * inside a 1024-byte module window.
 */
package rpc_pkg;

   // Clock period and the derived cycles per microsecond of busy hold time.
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int CYC_PER_US_I = US_NS / CLK_PERIOD_NS;
   localparam logic [6:0] CYC_PER_US_M1 = 7'(CYC_PER_US_I - 1);

   // Front-panel reset pulse length, rounded down to whole cycles.
   localparam int FP_PULSE_NS = 300;
   localparam int FP_PULSE_CYC_I = FP_PULSE_NS / CLK_PERIOD_NS;
   localparam logic [4:0] FP_PULSE_CYC = 5'(FP_PULSE_CYC_I);

   // Module window: upper half holds configuration, lower half relay data.
   localparam int ADDR_W = 10;
   localparam int CFG_SEL_BIT = 9;
   localparam logic [9:0] ADDR_CTRL = 10'h200;
   localparam logic [9:0] ADDR_DELAY = 10'h202;
   localparam logic [9:0] ADDR_STATUS = 10'h204;

   // Relay words held by this block and the address bits that pick one.
   localparam int RELAY_WORDS = 16;
   localparam int IDX_LSB = 1;
   localparam int IDX_MSB = 4;
   localparam int HOLE_LSB = 5;
   localparam int HOLE_MSB = 8;

   // Control register bit positions.
   localparam int CB_INV_RD = 9;
   localparam int CB_PF_DIS = 8;
   localparam int CB_SEQ_EN = 7;
   localparam int CB_SEQ_MBB = 6;
   localparam int CB_LED_RED = 5;
   localparam int CB_RST_EN = 4;
   localparam int CB_RST_SEL = 3;
   localparam int CB_OB_DRV = 2;
   localparam int CB_FP_POL = 1;
   localparam int CB_FP_LVL = 0;

   // Writable control bits and power-on values.
   localparam logic [15:0] CTRL_MASK = 16'h03ff;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] DELAY_RST = 16'h0000;

   // Status register layout.
   localparam int ST_FLAG = 0;
   localparam int ST_REV_LSB = 13;

   // Bank of relay words as seen by the relay drivers.
   typedef logic [RELAY_WORDS-1:0][15:0] rpc_bank_t;

   // Sequencer phases, Gray coded along idle, settle, final.
   typedef enum logic [1:0]
   {
      PH_IDLE = 2'b00,
      PH_SETTLE = 2'b01,
      PH_FINAL = 2'b11
   } rpc_phase_t;

endpackage

// [core/rpc_tmr_if.sv]
/*
 * Carrier between the relay control logic and its microsecond delay timer.
 * Assumes both ends run on the same clock and clock enable.
 */
`timescale 1ns/1ps
interface rpc_tmr_if;
   logic load;           // Start or restart the countdown.
   logic abort;          // Stop the countdown with no done pulse.
   logic [15:0] count_us; // Microseconds to count on a load.
   logic running;        // Countdown in progress.
   logic done;           // One-cycle pulse at the end of a countdown.

   // Controller end.
   modport ctl (output load, output abort, output count_us, input running, input done);
   // Timer end.
   modport tmr (input load, input abort, input count_us, output running, output done);
endinterface

// [core/rpc_busy_timer.sv]
/*
 * Microsecond delay timer: a prescaler of one microsecond and a 16-bit
 * countdown of microseconds, with a one-cycle done pulse.
 * Assumes the controller holds load for one cycle; load wins over abort.
 */
`timescale 1ns/1ps
module rpc_busy_timer
(
   // Clock, reset and freeze.
   input logic clock,
   input logic rstn,
   input logic ce,
   // Controller side.
   rpc_tmr_if.tmr t
);

   // All timer state in one record.
   typedef struct packed
   {
      logic [15:0] us_left;
      logic [6:0] pre;
      logic done;
   } rpc_tmr_state_t;

   rpc_tmr_state_t s_q; // Registered state.
   rpc_tmr_state_t s_d; // Next state.

   // Next state: a load restarts the prescaler so every count is a full 1 us.
   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (t.load)
      begin
         s_d.us_left = t.count_us;
         s_d.pre = rpc_pkg::CYC_PER_US_M1;
      end
      else if (t.abort)
      begin
         s_d.us_left = 16'h0000;
      end
      else if (s_q.us_left != 16'h0000)
      begin
         // One microsecond elapses each time the prescaler wraps.
         if (s_q.pre == 7'h00)
         begin
            s_d.pre = rpc_pkg::CYC_PER_US_M1;
            s_d.us_left = s_q.us_left - 16'h0001;
            s_d.done = (s_q.us_left == 16'h0001);
         end
         else
         begin
            s_d.pre = s_q.pre - 7'h01;
         end
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         s_q <= '0;
      else if (ce)
         s_q <= s_d;
   end

   assign t.running = (s_q.us_left != 16'h0000);
   assign t.done = s_q.done;

   done_cause_a: assert property (@(posedge clock) disable iff (!rstn)
      t.done |-> $past(t.running) && !t.running) else $error("done without countdown");

endmodule // rpc_busy_timer

// [core/rpc_relay_ctl.sv]
/*
 * Per-module control of a relay switch plug-in: relay data words, the
 * control, delay and status registers, break/make sequencing, busy hold time
 * and the relay-reset source selection.
 * Assumes a single-cycle register strobe port, inputs synchronous to clock
 * except the two interlock lines, and an open-drain shared open line that is
 * low while any module asserts it.
 */
`timescale 1ns/1ps

module rpc_relay_ctl
#(
   // Hardware revision code returned in status; the value is arbitrary.
   parameter logic [2:0] HW_REV = 3'h1
)
(
   // Clock, reset and freeze.
   input logic clock,
   input logic rstn,
   input logic ce,
   // Register port.
   input logic reg_sel,
   input logic reg_wr,
   input logic reg_rd,
   input logic [9:0] reg_addr,
   input logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   output logic reg_berr,
   // Chassis and front-panel lines.
   input logic power_loss_alert_n,
   input logic fp_open_in,
   input logic openbus_in,
   output logic openbus_out,
   output logic openbus_oe_n,
   // Relay side.
   output rpc_pkg::rpc_bank_t relay_drive,
   output logic relay_reset,
   output logic busy,
   output logic access_led_red
);

   // All state of the block in one record.
   typedef struct packed
   {
      rpc_pkg::rpc_bank_t relay;   // Words driven to the relays.
      logic [15:0] ctrl;           // Control register.
      logic [15:0] delay;          // Busy hold time in microseconds.
      logic flag;                  // Interlock activated.
      rpc_pkg::rpc_phase_t phase;  // Sequencer phase.
      logic [3:0] seq_idx;         // Word taking part in the sequence.
      logic [15:0] target;         // Final value of that word.
      logic [15:0] rdata;          // Read data.
      logic ack;                   // Access answered.
      logic berr;                  // Write refused.
      logic wr_seen;               // A relay write happened last cycle.
      logic fp_s1;                 // Interlock synchroniser, first stage.
      logic fp_s2;                 // Interlock synchroniser, second stage.
      logic fp_prev;               // Interlock, one cycle older.
      logic ob_s1;                 // Open line synchroniser, first stage.
      logic ob_s2;                 // Open line synchroniser, second stage.
      logic [4:0] pulse_cnt;       // Remaining cycles of the reset pulse.
   } rpc_state_t;

   rpc_state_t s_q; // Registered state.
   rpc_state_t s_d; // Next state.
   rpc_tmr_if tmr (); // Link to the delay timer.

   // True when an address falls on a relay word this block holds.
   function automatic logic relay_hit(input logic [9:0] a);
      relay_hit = !a[rpc_pkg::CFG_SEL_BIT] && (a[rpc_pkg::HOLE_MSB:rpc_pkg::HOLE_LSB] == 4'h0);
   endfunction
   // Intermediate word: break keeps only relays closed in both, make in either.
   function automatic logic [15:0] step_word(input logic [15:0] old_w, input logic [15:0] new_w,
                                             input logic make_before_break);
      step_word = make_before_break ? (old_w | new_w) : (old_w & new_w);
   endfunction
   // Interlock level as seen through the polarity bit.
   function automatic logic fp_active(input logic lvl, input logic pol);
      fp_active = pol ? lvl : !lvl;
   endfunction
   logic [3:0] acc_idx;     // Relay word addressed by the current access.
   logic wr_rel;            // Write to a held relay word.
   logic rd_rel;            // Read of a held relay word.
   logic seq_on;            // Sequencing really in effect.
   logic fp_pulse;          // Pulse-mode reset in progress.
   logic fp_event;          // Interlock asking for a reset.
   logic fp_edge;           // Active edge of the interlock.
   logic ob_active;         // Shared open line asserted.
   logic relay_rst_w;       // Reset of this module's relays.
   logic [15:0] word_sel;   // Addressed relay word.

   assign acc_idx = reg_addr[rpc_pkg::IDX_MSB:rpc_pkg::IDX_LSB];
   assign word_sel = s_q.relay[acc_idx];
   assign wr_rel = reg_sel && reg_wr && relay_hit(reg_addr);
   assign rd_rel = reg_sel && reg_rd && relay_hit(reg_addr);
   assign seq_on = s_q.ctrl[rpc_pkg::CB_SEQ_EN] && (s_q.delay != 16'h0000);

   assign fp_edge = fp_active(s_q.fp_s2, s_q.ctrl[rpc_pkg::CB_FP_POL])
                    && !fp_active(s_q.fp_prev, s_q.ctrl[rpc_pkg::CB_FP_POL]);
   assign fp_pulse = (s_q.pulse_cnt != 5'h00);
   assign fp_event = s_q.ctrl[rpc_pkg::CB_FP_LVL]
                     ? fp_active(s_q.fp_s2, s_q.ctrl[rpc_pkg::CB_FP_POL]) : fp_pulse;
   assign ob_active = !s_q.ob_s2;

   assign relay_rst_w = (s_q.ctrl[rpc_pkg::CB_RST_EN]
                         && (s_q.ctrl[rpc_pkg::CB_RST_SEL] ? ob_active : fp_event))
                        || (!s_q.ctrl[rpc_pkg::CB_PF_DIS] && !power_loss_alert_n);

   // Next state of registers, sequencer and interlock logic.
   always_comb
   begin
      s_d = s_q;
      tmr.load = 1'b0;
      tmr.abort = 1'b0;
      tmr.count_us = s_q.delay;
      s_d.ack = reg_sel && (reg_rd || reg_wr);
      s_d.berr = 1'b0;
      s_d.wr_seen = 1'b0;

      s_d.fp_s1 = fp_open_in;
      s_d.fp_s2 = s_q.fp_s1;
      s_d.fp_prev = s_q.fp_s2;
      s_d.ob_s1 = openbus_in;
      s_d.ob_s2 = s_q.ob_s1;

      if (fp_edge && !s_q.ctrl[rpc_pkg::CB_FP_LVL])
         s_d.pulse_cnt = rpc_pkg::FP_PULSE_CYC;
      else if (fp_pulse)
         s_d.pulse_cnt = s_q.pulse_cnt - 5'h01;

      // Configuration writes; reserved bits are never stored.
      if (reg_sel && reg_wr && (reg_addr == rpc_pkg::ADDR_CTRL))
         s_d.ctrl = reg_wdata & rpc_pkg::CTRL_MASK;
      if (reg_sel && reg_wr && (reg_addr == rpc_pkg::ADDR_DELAY))
         s_d.delay = reg_wdata;

      // Relay writes and the sequencer.
      unique case (s_q.phase)
         rpc_pkg::PH_IDLE:
         begin
            if (wr_rel)
            begin
               s_d.wr_seen = 1'b1;
               tmr.load = 1'b1;
               if (seq_on)
               begin
                  s_d.relay[acc_idx] = step_word(s_q.relay[acc_idx], reg_wdata,
                                                 s_q.ctrl[rpc_pkg::CB_SEQ_MBB]);
                  s_d.target = reg_wdata;
                  s_d.seq_idx = acc_idx;
                  s_d.phase = rpc_pkg::PH_SETTLE;
               end
               else
               begin
                  s_d.relay[acc_idx] = reg_wdata;
               end
            end
         end
         rpc_pkg::PH_SETTLE:
         begin
            if (wr_rel)
            begin
               s_d.wr_seen = 1'b1;
               tmr.load = 1'b1;
               if (acc_idx == s_q.seq_idx)
               begin
                  s_d.target = reg_wdata;
                  s_d.relay[acc_idx] = step_word(s_q.relay[acc_idx], reg_wdata,
                                                 s_q.ctrl[rpc_pkg::CB_SEQ_MBB]);
               end
               else
               begin
                  // Words outside the sequence are not sequenced at all.
                  s_d.relay[acc_idx] = reg_wdata;
               end
            end
            else if (!tmr.running)
            begin
               s_d.relay[s_q.seq_idx] = s_q.target;
               tmr.load = 1'b1;
               s_d.phase = rpc_pkg::PH_FINAL;
            end
         end
         rpc_pkg::PH_FINAL:
         begin
            s_d.berr = wr_rel;
            // A zero count never pulses done, so a stopped timer ends each phase.
            if (!tmr.running)
               s_d.phase = rpc_pkg::PH_IDLE;
         end
      endcase

      // A relay reset opens every relay and abandons any sequence.
      if (relay_rst_w)
      begin
         s_d.relay = '0;
         s_d.phase = rpc_pkg::PH_IDLE;
         tmr.abort = 1'b1;
         tmr.load = 1'b0;
      end

      s_d.rdata = 16'h0000;
      if (rd_rel)
         s_d.rdata = s_q.ctrl[rpc_pkg::CB_INV_RD] ? ~word_sel : word_sel;
      else if (reg_sel && reg_rd && (reg_addr == rpc_pkg::ADDR_CTRL))
         s_d.rdata = s_q.ctrl;
      else if (reg_sel && reg_rd && (reg_addr == rpc_pkg::ADDR_DELAY))
         s_d.rdata = s_q.delay;
      else if (reg_sel && reg_rd && (reg_addr == rpc_pkg::ADDR_STATUS))
      begin
         s_d.rdata[15:rpc_pkg::ST_REV_LSB] = HW_REV;
         s_d.rdata[rpc_pkg::ST_FLAG] = s_q.flag;
      end

      // read clears, a new activation wins
      if (reg_sel && reg_rd && (reg_addr == rpc_pkg::ADDR_STATUS))
         s_d.flag = 1'b0;
      if (fp_event && (s_q.ctrl[rpc_pkg::CB_RST_EN] || s_q.ctrl[rpc_pkg::CB_OB_DRV]))
         s_d.flag = 1'b1;
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q <= '0;
         s_q.ctrl <= rpc_pkg::CTRL_RST;
         s_q.delay <= rpc_pkg::DELAY_RST;
         s_q.phase <= rpc_pkg::PH_IDLE;
         // Idle lines are high, so the synchronisers start there.
         s_q.fp_s1 <= 1'b1;
         s_q.fp_s2 <= 1'b1;
         s_q.fp_prev <= 1'b1;
         s_q.ob_s1 <= 1'b1;
         s_q.ob_s2 <= 1'b1;
      end
      else if (ce)
         s_q <= s_d;
   end

   // Delay timer; it also times the busy hold of plain writes.
   rpc_busy_timer u_timer
   (
      .clock(clock),
      .rstn(rstn),
      .ce(ce),
      .t(tmr.tmr)
   );

   // Outputs.
   assign reg_rdata = s_q.rdata;
   assign reg_ack = s_q.ack;
   assign reg_berr = s_q.berr;
   assign relay_drive = s_q.relay;
   assign relay_reset = relay_rst_w;
   assign busy = s_q.wr_seen || tmr.running || (s_q.phase != rpc_pkg::PH_IDLE);
   assign access_led_red = s_q.ctrl[rpc_pkg::CB_LED_RED];
   assign openbus_out = 1'b0;
   assign openbus_oe_n = !(s_q.ctrl[rpc_pkg::CB_OB_DRV] && fp_event);

   default clocking dcb @(posedge clock); endclocking
   default disable iff (!rstn);

   inv_read_a: assert property (ce && rd_rel |=> reg_rdata ==
      ($past(s_q.ctrl[rpc_pkg::CB_INV_RD]) ? ~$past(word_sel) : $past(word_sel)))
      else $error("relay read-back polarity wrong");
   pfail_reset_a: assert property (ce && !power_loss_alert_n
      && !s_q.ctrl[rpc_pkg::CB_PF_DIS] |=> relay_drive == '0)
      else $error("power fail did not open relays");
   direct_write_a: assert property (ce && wr_rel && !relay_rst_w
      && !s_q.ctrl[rpc_pkg::CB_SEQ_EN] && s_q.phase == rpc_pkg::PH_IDLE
      |=> relay_drive[$past(acc_idx)] == $past(reg_wdata))
      else $error("direct relay write not applied");
   final_refuse_a: assert property (ce && wr_rel && s_q.phase == rpc_pkg::PH_FINAL
      |=> reg_berr && relay_drive == $past(relay_drive))
      else $error("final-phase write not refused");
   seq_busy_a: assert property (s_q.phase != rpc_pkg::PH_IDLE |-> busy)
      else $error("busy dropped during sequence");
   gate_reset_a: assert property (!s_q.ctrl[rpc_pkg::CB_RST_EN] && power_loss_alert_n
      |-> !relay_reset)
      else $error("relay reset while sources disabled");
   pulse_len_a: assert property ($rose(fp_pulse) |-> fp_pulse[*8])
      else $error("reset pulse too short");
   flag_clear_a: assert property (ce && reg_sel && reg_rd
      && reg_addr == rpc_pkg::ADDR_STATUS && !fp_event |=> !s_q.flag)
      else $error("status read did not clear flag");
   write_busy_a: assert property (ce && wr_rel && s_q.phase != rpc_pkg::PH_FINAL
      |=> busy)
      else $error("relay write did not raise busy");

   seq_done_c: cover property (s_q.phase == rpc_pkg::PH_FINAL ##1 s_q.phase == rpc_pkg::PH_IDLE);
   fp_pulse_c: cover property ($rose(fp_pulse) && relay_reset);
   berr_c: cover property (reg_berr);
   flag_read_c: cover property (s_q.flag && reg_sel && reg_rd && reg_addr == rpc_pkg::ADDR_STATUS);
endmodule // rpc_relay_ctl

// [test/rpc_host_model.sv]
/*
 * Bus host model for the relay plug-in control block: one task that makes a
 * single-strobe register read or write and collects the answer.
 * Assumes the block acknowledges one cycle after the strobe edge.
 */
`timescale 1ns/1ps
module rpc_host_model
(
   // Clock.
   input wire logic clock,
   // Requests towards the block.
   output logic reg_sel,
   output logic reg_wr,
   output logic reg_rd,
   output logic [9:0] reg_addr,
   output logic [15:0] reg_wdata,
   // Answers from the block.
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_berr,
   // Set when an answer never came.
   output logic lost
);
   // Idle bus at time zero.
   initial
   begin
      reg_sel = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      lost = 1'b0;
   end

   // One access; released address and data lines show inverted values so stale data never looks valid.
   task automatic xfer(input logic wr, input logic [9:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic be);
      int i;
      @(posedge clock);
      reg_sel <= 1'b1;
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_sel <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      i = 0;
      // The answer is bounded; a missing one marks the bus lost.
      do
      begin
         @(posedge clock);
         i++;
      end
      while (reg_ack !== 1'b1 && i < 4);
      q = reg_rdata;
      be = reg_berr;
      if (reg_ack !== 1'b1)
         lost = 1'b1;
   endtask
endmodule // rpc_host_model

// [test/rpc_relay_ctl_tb_top.sv]
/*
 * Self-checking bench for the relay plug-in control block.
 * Assumes the host model above and the design's rpc_pkg constants.
 */
`timescale 1ns/1ps
module rpc_relay_ctl_tb_top;
   // Revision code handed to the block; the value is arbitrary.
   localparam logic [2:0] REV = 3'h5;
   typedef struct packed {logic [9:0] wa; logic [15:0] d; logic [9:0] ra; logic [15:0] r;} rpc_row_t;
   logic clock, rstn, ce, pla_n, fp_open_in, ob_ext, lost;
   logic reg_sel, reg_wr, reg_rd, reg_ack, reg_berr, openbus_out, openbus_oe_n;
   logic relay_reset, busy, access_led_red;
   logic [9:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   rpc_pkg::rpc_bank_t relay_drive;
   int err_total, num_checks, n;
   // Open line is pulled up; any party pulling it wins.
   wire openbus_in = ob_ext & (openbus_oe_n ? 1'b1 : openbus_out);
   wire [2:0] mon = {openbus_oe_n, relay_reset, busy};
   // Ordinary cases: write, then read back the expected word.
   rpc_row_t rows [8] = '{
      '{10'h200, 16'hfc00, 10'h200, 16'h0000}, '{10'h002, 16'h00ff, 10'h002, 16'h00ff},
      '{10'h01f, 16'hffff, 10'h01e, 16'hffff}, '{10'h020, 16'h1234, 10'h020, 16'h0000},
      '{10'h206, 16'h5555, 10'h206, 16'h0000}, '{10'h204, 16'hffff, 10'h204, {REV, 13'h0}},
      '{10'h202, 16'hffff, 10'h202, 16'hffff}, '{10'h202, 16'h0001, 10'h202, 16'h0001}};

   rpc_relay_ctl #(.HW_REV(REV)) i_dut (.clock(clock), .rstn(rstn), .ce(ce), .reg_sel(reg_sel),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_berr(reg_berr),
      .power_loss_alert_n(pla_n), .fp_open_in(fp_open_in), .openbus_in(openbus_in),
      .openbus_out(openbus_out), .openbus_oe_n(openbus_oe_n), .relay_drive(relay_drive),
      .relay_reset(relay_reset), .busy(busy), .access_led_red(access_led_red));
   rpc_host_model i_host (.clock(clock), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_berr(reg_berr), .lost(lost));

   // Free-running 100 MHz clock.
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Verdict and end of run, reached from every path.
   task automatic end_sim;
      // A register access that never got an answer fails the run.
      if (lost === 1'b1)
      begin
         err_total++;
         $display("mismatch at %0t: register port never answered", $time);
      end
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Compare of a word result.
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   // Compare of a flag result.
   task automatic chk_b(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // Bounded wait for a monitored output to reach a level; n counts the cycles.
   task automatic wait_for(input int s, input logic v, output int cnt);
      cnt = 0;
      while (mon[s] !== v && cnt < 1000)
      begin
         @(posedge clock);
         cnt++;
      end
      if (mon[s] !== v)
      begin
         err_total++;
         $display("mismatch at %0t: wait ran out", $time);
         end_sim;
      end
   endtask

   // Register write with the expected refusal flag, and register read.
   task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic be_exp);
      logic [15:0] q;
      logic be;
      i_host.xfer(1'b1, a, d, q, be);
      if (lost === 1'b1)
         end_sim;
      chk_b(be, be_exp);
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      logic [15:0] q;
      logic be;
      i_host.xfer(1'b0, a, 16'h0000, q, be);
      if (lost === 1'b1)
         end_sim;
      chk_w(q, exp);
   endtask

   // Main sequence.
   initial
   begin
      err_total = 0;
      num_checks = 0;
      rstn = 1'b0;
      ce = 1'b1;
      pla_n = 1'b1;
      fp_open_in = 1'b1;
      ob_ext = 1'b1;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      // Power-on state of the outputs.
      for (int i = 0; i < 16; i++)
         chk_w(relay_drive[i], 16'h0000);
      chk_b(busy | access_led_red | ~openbus_oe_n, 1'b0);
      // Table of register and window cases.
      foreach (rows[i])
      begin
         wr(rows[i].wa, rows[i].d, 1'b0);
         rd(rows[i].ra, rows[i].r);
      end
      // Read-back polarity affects relay words only.
      wr(10'h200, 16'h0200, 1'b0);
      rd(10'h002, 16'hff00);
      rd(10'h200, 16'h0200);
      rd(10'h202, 16'h0001);
      wr(10'h200, 16'h0020, 1'b0);
      chk_b(access_led_red, 1'b1);
      wr(10'h200, 16'h0000, 1'b0);
      chk_b(access_led_red, 1'b0);
      // Plain write with a 2 us hold time.
      wr(10'h202, 16'h0002, 1'b0);
      wr(10'h006, 16'hbeef, 1'b0);
      chk_w(relay_drive[3], 16'hbeef);
      chk_b(busy, 1'b1);
      wait_for(0, 1'b0, n);
      chk_b(n >= 197 && n <= 202, 1'b1);
      // Break-before-make, restarted in settle, refused in final.
      wr(10'h202, 16'h0001, 1'b0);
      wr(10'h004, 16'h00ff, 1'b0);
      wr(10'h200, 16'h0080, 1'b0);
      wr(10'h004, 16'h0ff0, 1'b0);
      chk_w(relay_drive[2], 16'h00f0);
      repeat (50) @(posedge clock);
      wr(10'h004, 16'h0ff0, 1'b0);
      repeat (140) @(posedge clock);
      chk_w(relay_drive[2], 16'h0ff0);
      chk_b(busy, 1'b1);
      wr(10'h004, 16'h0000, 1'b1);
      wait_for(0, 1'b0, n);
      chk_w(relay_drive[2], 16'h0ff0);
      // Make-before-break steps through the union.
      wr(10'h200, 16'h00c0, 1'b0);
      wr(10'h004, 16'h00ff, 1'b0);
      chk_w(relay_drive[2], 16'h0fff);
      wait_for(0, 1'b0, n);
      chk_w(relay_drive[2], 16'h00ff);
      // Sequencing with no delay loaded acts as immediate.
      wr(10'h202, 16'h0000, 1'b0);
      wr(10'h008, 16'h1111, 1'b0);
      chk_w(relay_drive[4], 16'h1111);
      #1 chk_b(busy, 1'b0);
      // Power-fail reset, then disabled.
      wr(10'h200, 16'h0000, 1'b0);
      pla_n <= 1'b0;
      @(posedge clock);
      #1 chk_b(relay_reset, 1'b1);
      @(posedge clock);
      chk_w(relay_drive[4], 16'h0000);
      pla_n <= 1'b1;
      wr(10'h200, 16'h0100, 1'b0);
      pla_n <= 1'b0;
      @(posedge clock);
      #1 chk_b(relay_reset, 1'b0);
      @(posedge clock) pla_n <= 1'b1;
      // Falling-edge pulse on the interlock, then the status flag.
      wr(10'h200, 16'h0010, 1'b0);
      fp_open_in <= 1'b0;
      wait_for(1, 1'b1, n);
      wait_for(1, 1'b0, n);
      chk_b(n >= 29 && n <= 31, 1'b1);
      rd(10'h204, {REV, 13'h1});
      rd(10'h204, {REV, 13'h0});
      // Inverted level mode holds reset while high.
      wr(10'h200, 16'h0013, 1'b0);
      fp_open_in <= 1'b1;
      wait_for(1, 1'b1, n);
      repeat (40) @(posedge clock);
      chk_b(relay_reset, 1'b1);
      fp_open_in <= 1'b0;
      wait_for(1, 1'b0, n);
      // Interlock drives the open line but may not reset relays.
      wr(10'h200, 16'h0004, 1'b0);
      fp_open_in <= 1'b1;
      @(posedge clock);
      fp_open_in <= 1'b0;
      wait_for(2, 1'b0, n);
      chk_b(openbus_out, 1'b0);
      chk_b(relay_reset, 1'b0);
      wait_for(2, 1'b1, n);
      // Open line as reset source, then with reset disabled.
      wr(10'h200, 16'h0018, 1'b0);
      ob_ext <= 1'b0;
      wait_for(1, 1'b1, n);
      ob_ext <= 1'b1;
      wait_for(1, 1'b0, n);
      wr(10'h200, 16'h0008, 1'b0);
      ob_ext <= 1'b0;
      repeat (6) @(posedge clock);
      chk_b(relay_reset, 1'b0);
      // Reset in mid-run returns relays and registers to power-on values.
      wr(10'h004, 16'h0f0f, 1'b0);
      chk_w(relay_drive[2], 16'h0f0f);
      wr(10'h202, 16'h0007, 1'b0);
      @(posedge clock) rstn <= 1'b0;
      @(posedge clock) rstn <= 1'b1;
      chk_w(relay_drive[2], 16'h0000);
      rd(10'h202, 16'h0000);
      end_sim;
   end
endmodule // rpc_relay_ctl_tb_top
